// [odsr_pkg.sv]
// Operation
// RULE1 - With step select 0, fine delay is about 254ps per code step: 0, 254, 507, 763ps.
// RULE2 - With step select 1, fine delay step becomes half a VCO period, four steps.
// RULE3 - Analog delay adds code times 30ps on top of fine delay, resets to 000.
// RULE4 - Oscillator output powered when power-down bit is 0, off when 1; resets 0.
// RULE5 - Oscillator format bit: 0 selects LVDS 350mV, 1 selects LVPECL 700mV; resets 0.
// RULE6 - Each 4-bit pin function field picks the pin role; other codes are reserved. Codes 7 and f act only in pin 0's field and also set pin 1's role.
// RULE7 - Polarity bit 1 inverts all status driven on the pins; 0 keeps normal.
// RULE8 - Enable 0 masks a condition; enable 1 lets it drive interrupt pins.
// RULE9 - Latched bit reads 0 after a loss event; writing 1 clears it and its interrupt.
// RULE10 - Live bits show current conditions on every read; writes are ignored.
package odsr_pkg;

  // Register offsets
  localparam logic [14:0] ODSR_OFS_OUT_BASE = 15'h0040; // One word per delayed output
  localparam logic [14:0] ODSR_OFS_OSC      = 15'h003f;
  localparam logic [14:0] ODSR_OFS_PIN_FUNC = 15'h0088;
  localparam logic [14:0] ODSR_OFS_PIN_POL  = 15'h0089;
  localparam logic [14:0] ODSR_OFS_INT_EN   = 15'h008c;
  localparam logic [14:0] ODSR_OFS_LATCHED  = 15'h0090;
  localparam logic [14:0] ODSR_OFS_LIVE     = 15'h0094;
  localparam logic [14:0] ODSR_OFS_REFSEL   = 15'h0096;
  localparam logic [14:0] ODSR_OFS_OSCINIT  = 15'h0097;

  // Reset values
  localparam logic [7:0] ODSR_RST_PIN_FUNC = 8'hab;
  localparam logic [7:0] ODSR_RST_LATCHED  = 8'hff;
  localparam logic [7:0] ODSR_RST_ZERO     = 8'h00;

  // Per-output word fields
  localparam int ODSR_FINE_LSB  = 0;
  localparam int ODSR_ANLG_LSB  = 2;
  localparam int ODSR_RETIME_BIT = 7;
  localparam logic [7:0] ODSR_OUT_MASK = 8'h9f;
  // Oscillator word fields
  localparam int ODSR_OSC_PD_BIT  = 0;
  localparam int ODSR_OSC_FMT_BIT = 1;
  localparam logic [7:0] ODSR_OSC_MASK = 8'h03;
  // Condition bit positions in status and enable words
  localparam int ODSR_B_HOLD = 1;
  localparam int ODSR_B_LOCK1 = 2;
  localparam int ODSR_B_LOCK0 = 3;
  localparam int ODSR_B_CLK_LO = 4;

  // Delay figures in picoseconds
  localparam int ODSR_DLY_W = 18;
  localparam logic [ODSR_DLY_W-1:0] ODSR_FINE_PS1 = 18'h000fe; // 254ps
  localparam logic [ODSR_DLY_W-1:0] ODSR_FINE_PS2 = 18'h001fb; // 507ps
  localparam logic [ODSR_DLY_W-1:0] ODSR_FINE_PS3 = 18'h002fb; // 763ps
  localparam logic [ODSR_DLY_W-1:0] ODSR_ANLG_PS  = 18'h0001e; // 30ps

  // Pin function codes
  typedef enum logic [3:0] {
    ODSR_FN_FORCE_HOLD = 4'h1,
    ODSR_FN_FORCE_CV   = 4'h2,
    ODSR_FN_IN_SELECT  = 4'h7,
    ODSR_FN_LOCK0      = 4'h8,
    ODSR_FN_LOCK1      = 4'h9,
    ODSR_FN_LOCK_BOTH  = 4'ha,
    ODSR_FN_ALARM      = 4'hb,
    ODSR_FN_HOLDOVER   = 4'hc,
    ODSR_FN_IRQ        = 4'hd,
    ODSR_FN_SEL_SHOW   = 4'hf
  } odsr_pin_fn_t;

  // Serial frame layout
  localparam logic [4:0] ODSR_HDR_BITS   = 5'h10;
  localparam logic [4:0] ODSR_FRAME_BITS = 5'h18;

endpackage : odsr_pkg

// [odsr_bus_if.sv]
// Register access between serial port and register bank
interface odsr_bus_if;
  logic        wr_stb; // One-cycle write strobe
  logic [14:0] addr;   // Register offset
  logic [7:0]  wdata;  // Write data
  logic [7:0]  rdata;  // Read data for addr

  modport port (output wr_stb, output addr, output wdata, input rdata);
  modport bank (input wr_stb, input addr, input wdata, output rdata);
endinterface : odsr_bus_if

// [odsr_spi_port.sv]
// Serial configuration port: R/W bit, 15-bit offset, 8 data bits, MSB first
module odsr_spi_port
  import odsr_pkg::*;
(
  input  wire logic clk_i,      // 25 MHz clock
  input  wire logic srst_i,     // Synchronous reset
  input  wire logic sclk_i,     // Serial clock pin
  input  wire logic cs_n_i,     // Chip select pin, active low
  input  wire logic sdi_i,      // Serial data in pin
  output logic      sdo_o,      // Serial data out
  output logic      sdo_oe_o,   // Serial data out enable
  odsr_bus_if.port  bus         // Register access
);

  logic [2:0]  s1_q, s2_q, s3_q; // {cs_n, sclk, sdi} sync stages
  logic [4:0]  cnt_q;
  logic [15:0] hdr_q;
  logic [7:0]  sh_q;
  logic        rd_q;
  logic        rise, fall, active;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser, third stage only for edge detect
  always_ff @(posedge clk_i) begin
    s1_q <= {cs_n_i, sclk_i, sdi_i};
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  assign active = ~s2_q[2];
  assign rise   = active & s2_q[1] & ~s3_q[1];
  assign fall   = active & ~s2_q[1] & s3_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bit counter and header capture
  always_ff @(posedge clk_i) begin
    if (srst_i || !active) begin
      cnt_q <= 5'h00;
      hdr_q <= 16'h0000;
    end else if (rise && cnt_q != ODSR_FRAME_BITS) begin
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q < ODSR_HDR_BITS) begin
        hdr_q <= {hdr_q[14:0], s2_q[0]};
      end
    end
  end

  assign bus.addr = hdr_q[14:0];
  assign rd_q     = hdr_q[15];

  // Data shift: write data in on rising edges; read data loaded after header, shifted out on falling edges
  always_ff @(posedge clk_i) begin
    if (srst_i || !active) begin
      sh_q <= 8'h00;
    end else if (cnt_q == ODSR_HDR_BITS && !rd_q && rise) begin
      sh_q <= {sh_q[6:0], s2_q[0]};
    end else if (cnt_q > ODSR_HDR_BITS && cnt_q != ODSR_FRAME_BITS && !rd_q && rise) begin
      sh_q <= {sh_q[6:0], s2_q[0]};
    end else if (rise && cnt_q == ODSR_HDR_BITS - 5'h01) begin
      sh_q <= 8'h00;
    end else if (rd_q && cnt_q == ODSR_HDR_BITS && fall) begin
      sh_q <= bus.rdata;
    end else if (rd_q && cnt_q > ODSR_HDR_BITS && fall) begin
      sh_q <= {sh_q[6:0], 1'b0};
    end
  end

  // Write strobe on the last data bit
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bus.wr_stb <= 1'b0;
      bus.wdata  <= 8'h00;
    end else begin
      bus.wr_stb <= rise && !rd_q && cnt_q == ODSR_FRAME_BITS - 5'h01;
      bus.wdata  <= {sh_q[6:0], s2_q[0]};
    end
  end

  // Read data out while a read frame is in its data phase
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_oe_o <= active && rd_q && cnt_q >= ODSR_HDR_BITS && cnt_q != ODSR_FRAME_BITS;
      sdo_o    <= sh_q[7];
    end
  end

endmodule : odsr_spi_port

// [odsr_top.sv]
// Output delay and status register bank
module odsr_top
  import odsr_pkg::*;
#(
  parameter int NUM_OUT = 14 // Outputs with delay fields
) (
  input  wire logic                    clk_i,       // 25 MHz clock
  input  wire logic                    srst_i,      // Synchronous reset
  input  wire logic                    sclk_i,      // Serial clock pin
  input  wire logic                    cs_n_i,      // Chip select, active low
  input  wire logic                    sdi_i,       // Serial data in
  output logic                         sdo_o,       // Serial data out
  output logic                         sdo_oe_o,    // Serial data out enable
  input  wire logic [15:0]             vco_half_ps_i, // Half VCO period, ps
  output logic [NUM_OUT*ODSR_DLY_W-1:0] delay_ps_o,  // Total delay per output, ps
  output logic                         osc_out_en_o,  // Oscillator output powered
  output logic                         osc_out_fmt_o, // 0 LVDS 350mV, 1 LVPECL 700mV
  input  wire logic [7:0]              cond_i,      // Live conditions, status layout
  input  wire logic [4:0]              refsel_i,    // {fcv0, ri, ref[1:0], initref}
  input  wire logic [1:0]              gpio_i,      // Pin inputs
  output logic [1:0]                   gpio_o,      // Pin outputs
  output logic [1:0]                   gpio_oe_o,   // Pin output enables
  output logic                         force_hold_o, // Force holdover request
  output logic                         force_cv_o,   // Force control voltage request
  output logic                         pin_sel_en_o, // Input chosen by pins
  output logic [1:0]                   pin_sel_o     // Input chosen by pins
);

  // Refuse counts whose words would run into the control offsets
  if (NUM_OUT < 1 || NUM_OUT > 64) begin : g_bad_num
    $error("NUM_OUT out of range");
  end

  odsr_bus_if bus ();

  logic [7:0]  out_q [NUM_OUT];
  logic [7:0]  osc_q, func_q, pol_q, en_q, lat_q;
  logic [12:0] st1_q, st2_q;
  logic [1:0]  gp1_q, gp2_q;
  logic [7:0]  live, bad, rdata;
  logic        irq;

  ////////////////////////////////////////////////////////////////////////////
  // Serial port
  odsr_spi_port u_port (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .sclk_i   (sclk_i),
    .cs_n_i   (cs_n_i),
    .sdi_i    (sdi_i),
    .sdo_o    (sdo_o),
    .sdo_oe_o (sdo_oe_o),
    .bus      (bus.port)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status and pin synchronisers
  always_ff @(posedge clk_i) begin
    st1_q <= {cond_i, refsel_i};
    st2_q <= st1_q;
    gp1_q <= gpio_i;
    gp2_q <= gp1_q;
  end

  assign live = st2_q[12:5]; // RULE10

  // Per-output delay words
  for (genvar y = 0; y < NUM_OUT; y++) begin : g_out
    logic [ODSR_DLY_W-1:0] fine_ps;
    logic [ODSR_DLY_W-1:0] anlg_ps;
    logic [1:0]            fine;
    logic [2:0]            anlg;

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        out_q[y] <= ODSR_RST_ZERO; // RULE1 RULE3
      end else if (bus.wr_stb && bus.addr == ODSR_OFS_OUT_BASE + 15'(y)) begin
        out_q[y] <= bus.wdata & ODSR_OUT_MASK;
      end
    end

    assign fine = out_q[y][ODSR_FINE_LSB +: 2];
    assign anlg = out_q[y][ODSR_ANLG_LSB +: 3];

    // Fine step: fixed table, or half VCO period per step
    always_comb begin
      if (out_q[y][ODSR_RETIME_BIT]) begin
        fine_ps = ODSR_DLY_W'(vco_half_ps_i) * ODSR_DLY_W'(fine); // RULE2
      end else begin
        unique case (fine) // RULE1
          2'h0: fine_ps = '0;
          2'h1: fine_ps = ODSR_FINE_PS1;
          2'h2: fine_ps = ODSR_FINE_PS2;
          2'h3: fine_ps = ODSR_FINE_PS3;
        endcase
      end
      anlg_ps = ODSR_ANLG_PS * ODSR_DLY_W'(anlg); // RULE3
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        delay_ps_o[y*ODSR_DLY_W +: ODSR_DLY_W] <= '0;
      end else begin
        delay_ps_o[y*ODSR_DLY_W +: ODSR_DLY_W] <= fine_ps + anlg_ps; // RULE3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_q  <= ODSR_RST_ZERO; // RULE4 RULE5
      func_q <= ODSR_RST_PIN_FUNC;
      pol_q  <= ODSR_RST_ZERO;
      en_q   <= ODSR_RST_ZERO;
    end else if (bus.wr_stb) begin
      if (bus.addr == ODSR_OFS_OSC)      osc_q  <= bus.wdata & ODSR_OSC_MASK;
      if (bus.addr == ODSR_OFS_PIN_FUNC) func_q <= bus.wdata; // RULE6
      if (bus.addr == ODSR_OFS_PIN_POL)  pol_q  <= {7'h00, bus.wdata[0]}; // RULE7
      if (bus.addr == ODSR_OFS_INT_EN)   en_q   <= bus.wdata; // RULE8
    end
  end

  // Oscillator output controls
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_out_en_o  <= 1'b1;
      osc_out_fmt_o <= 1'b0;
    end else begin
      osc_out_en_o  <= ~osc_q[ODSR_OSC_PD_BIT]; // RULE4
      osc_out_fmt_o <= osc_q[ODSR_OSC_FMT_BIT]; // RULE5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loss events: holdover bit is bad when high, the rest when low
  assign bad = ~live ^ (8'h01 << ODSR_B_HOLD);

  // Latched status, event wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lat_q <= ODSR_RST_LATCHED;
    end else if (bus.wr_stb && bus.addr == ODSR_OFS_LATCHED) begin
      lat_q <= (lat_q | bus.wdata) & ~bad; // RULE9
    end else begin
      lat_q <= lat_q & ~bad; // RULE9
    end
  end

  assign irq = |(en_q & ~lat_q); // RULE8 RULE9

  // Read mux
  always_comb begin
    rdata = 8'h00;
    for (int y = 0; y < NUM_OUT; y++) begin
      if (bus.addr == ODSR_OFS_OUT_BASE + 15'(y)) rdata = out_q[y];
    end
    unique case (bus.addr)
      ODSR_OFS_OSC:      rdata = osc_q;
      ODSR_OFS_PIN_FUNC: rdata = func_q;
      ODSR_OFS_PIN_POL:  rdata = pol_q;
      ODSR_OFS_INT_EN:   rdata = en_q;
      ODSR_OFS_LATCHED:  rdata = lat_q;
      ODSR_OFS_LIVE:     rdata = live; // RULE10
      ODSR_OFS_REFSEL:   rdata = {st2_q[4], 1'b0, st2_q[3:1], 3'h0}; // RULE10
      ODSR_OFS_OSCINIT:  rdata = {5'h00, st2_q[0], 2'h0}; // RULE10
      default: ;
    endcase
  end
  assign bus.rdata = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Pin roles
  for (genvar p = 0; p < 2; p++) begin : g_pin
    logic [3:0] fn;
    logic       val;
    logic       drv;
    assign fn = func_q[p*4 +: 4];

    always_comb begin
      drv = 1'b1;
      val = 1'b0;
      unique case (fn) // RULE6
        ODSR_FN_LOCK0:     val = live[ODSR_B_LOCK0];
        ODSR_FN_LOCK1:     val = live[ODSR_B_LOCK1];
        ODSR_FN_LOCK_BOTH: val = live[ODSR_B_LOCK0] & live[ODSR_B_LOCK1];
        ODSR_FN_ALARM:     val = ~&live[ODSR_B_CLK_LO +: 4];
        ODSR_FN_HOLDOVER:  val = live[ODSR_B_HOLD];
        ODSR_FN_IRQ:       val = irq; // RULE8
        ODSR_FN_SEL_SHOW:  begin
          val = st2_q[1 + p];
          drv = (p == 0);
        end
        default:           drv = 1'b0;
      endcase
      if (p == 1 && func_q[3:0] == ODSR_FN_SEL_SHOW) begin
        val = st2_q[2];
        drv = 1'b1;
      end else if (p == 1 && func_q[3:0] == ODSR_FN_IN_SELECT) begin
        drv = 1'b0; // RULE6
      end
    end

    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        gpio_o[p]    <= 1'b0;
        gpio_oe_o[p] <= 1'b0;
      end else begin
        gpio_o[p]    <= val ^ pol_q[0]; // RULE7
        gpio_oe_o[p] <= drv;
      end
    end
  end

  // Pin-driven requests
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      force_hold_o <= 1'b0;
      force_cv_o   <= 1'b0;
      pin_sel_en_o <= 1'b0;
      pin_sel_o    <= 2'h0;
    end else begin
      force_hold_o <= (func_q[3:0] == ODSR_FN_FORCE_HOLD && gp2_q[0])
                    | (func_q[7:4] == ODSR_FN_FORCE_HOLD && gp2_q[1]); // RULE6
      force_cv_o   <= (func_q[3:0] == ODSR_FN_FORCE_CV && gp2_q[0])
                    | (func_q[7:4] == ODSR_FN_FORCE_CV && gp2_q[1]);
      pin_sel_en_o <= func_q[3:0] == ODSR_FN_IN_SELECT;
      pin_sel_o    <= gp2_q;
    end
  end

endmodule : odsr_top

// [odsr_top_chk.sv]
// Port-level checks for the register bank
module odsr_top_chk
  import odsr_pkg::*;
#(
  parameter int NUM_OUT = 14 // Outputs with delay fields
) (
  input wire logic                        clk_i,         // Clock
  input wire logic                        srst_i,        // Sync reset
  input wire logic                        cs_n_i,        // Chip select
  input wire logic                        sdo_oe_o,      // Read drive
  input wire logic [15:0]                 vco_half_ps_i, // Half VCO period
  input wire logic [NUM_OUT*ODSR_DLY_W-1:0] delay_ps_o,  // Delays
  input wire logic                        osc_out_en_o,  // Osc powered
  input wire logic                        osc_out_fmt_o, // Osc format
  input wire logic [1:0]                  gpio_oe_o,     // Pin enables
  input wire logic                        force_hold_o,  // Force holdover
  input wire logic                        force_cv_o,    // Force voltage
  input wire logic                        pin_sel_en_o   // Pin selection
);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since last frame or VCO change; settings may only move after those
  logic [3:0] quiet_q;
  always_ff @(posedge clk_i) begin
    if (srst_i || !cs_n_i || $changed(vco_half_ps_i)) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence cs_idle_s; cs_n_i [*5]; endsequence
  sequence all_out_s; (gpio_oe_o == 2'b11) [*3]; endsequence
  idle_no_drive_a: assert property (cs_idle_s |-> !sdo_oe_o)
    else $error("serial out driven while deselected");
  delay_hold_a: assert property (quiet_q > 4'h7 |-> $stable(delay_ps_o))
    else $error("delay moved without a write");
  osc_hold_a: assert property (quiet_q > 4'h7 |-> $stable({osc_out_en_o, osc_out_fmt_o}))
    else $error("osc control moved without a write");
  rst_vals_a: assert property (disable iff (1'b0)
    srst_i |=> osc_out_en_o && !osc_out_fmt_o && delay_ps_o == '0)
    else $error("wrong reset value on outputs");
  rst_pins_a: assert property (disable iff (1'b0)
    srst_i |=> gpio_oe_o == 2'b00 && !sdo_oe_o)
    else $error("pins driven in reset");
  dflt_pins_a: assert property ($fell(srst_i) |-> ##[1:3] gpio_oe_o == 2'b11)
    else $error("default pin roles not output");
  out_no_force_a: assert property (all_out_s |->
    !force_hold_o && !force_cv_o && !pin_sel_en_o)
    else $error("input role active on output pins");
  sel_pin_in_a: assert property (pin_sel_en_o [*3] |-> gpio_oe_o == 2'b00)
    else $error("select pin driven");
endmodule : odsr_top_chk

bind odsr_top odsr_top_chk #(.NUM_OUT(NUM_OUT)) u_chk (.clk_i, .srst_i, .cs_n_i, .sdo_oe_o,
  .vco_half_ps_i, .delay_ps_o, .osc_out_en_o, .osc_out_fmt_o, .gpio_oe_o, .force_hold_o,
  .force_cv_o, .pin_sel_en_o);

// [test_odsr_top.sv]
// Testbench for the register bank
module test_odsr_top
  import odsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 14;
  logic                  clk_i, srst_i, sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o;
  logic                  osc_out_en_o, osc_out_fmt_o, force_hold_o, force_cv_o, pin_sel_en_o;
  logic [15:0]           vco_half_ps_i;
  logic [N*ODSR_DLY_W-1:0] delay_ps_o;
  logic [7:0]            cond_i;
  logic [4:0]            refsel_i;
  logic [1:0]            gpio_i, gpio_o, gpio_oe_o, pin_sel_o;
  int                    n_fail, n_compared;
  int                    fine[4] = '{0, 254, 507, 763};

  odsr_top #(.NUM_OUT(N)) uut (.clk_i, .srst_i, .sclk_i, .cs_n_i, .sdi_i, .sdo_o, .sdo_oe_o,
    .vco_half_ps_i, .delay_ps_o, .osc_out_en_o, .osc_out_fmt_o, .cond_i, .refsel_i, .gpio_i,
    .gpio_o, .gpio_oe_o, .force_hold_o, .force_cv_o, .pin_sel_en_o, .pin_sel_o);

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // One frame: R/W bit, offset, data, MSB first; sclk phases 4 clocks each
  task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                      output logic [7:0] rdv);
    logic [23:0] f;
    f = {rd, a, wd};
    cs_n_i = 1'b0;
    clks(4);
    for (int i = 0; i < 24; i++) begin
      sclk_i = 1'b0;
      sdi_i = f[23-i];
      clks(4);
      if (i > 15) rdv[23-i] = sdo_o;
      sclk_i = 1'b1;
      clks(4);
    end
    sclk_i = 1'b0;
    sdi_i = 1'b0;
    clks(2);
    cs_n_i = 1'b1;
    clks(6);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] v;
    xfer(1'b0, a, d, v);
  endtask

  task automatic rd(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] v;
    xfer(1'b1, a, 8'h00, v);
    chk(v, exp);
  endtask

  task automatic end_sim();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the expected run
  initial begin
    #(40 * 60000);
    n_fail++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic e;
    srst_i = 1'b1;
    cs_n_i = 1'b1;
    sclk_i = 1'b0;
    sdi_i = 1'b0;
    vco_half_ps_i = 16'h01fd;
    cond_i = 8'hfd;
    refsel_i = 5'h17;
    gpio_i = 2'b00;
    n_fail = 0;
    n_compared = 0;
    clks(2);
    srst_i = 1'b0;
    clks(4);
    chk({osc_out_en_o, osc_out_fmt_o, delay_ps_o[17:0]}, 32'h80000);
    rd(ODSR_OFS_PIN_FUNC, ODSR_RST_PIN_FUNC);
    rd(ODSR_OFS_PIN_POL, 8'h00);
    rd(ODSR_OFS_INT_EN, 8'h00);
    rd(ODSR_OFS_OUT_BASE, 8'h00);
    rd(ODSR_OFS_OSC, 8'h00);
    // Every fine code, analog at both ends
    for (int k = 0; k < 8; k++) begin
      wr(ODSR_OFS_OUT_BASE, {3'h0, k[2] ? 3'h7 : 3'h0, k[1:0]});
      chk(delay_ps_o[17:0], fine[k[1:0]] + (k[2] ? 7 * 30 : 0));
    end
    wr(ODSR_OFS_OUT_BASE + 15'(N - 1), 8'h9d);
    chk(delay_ps_o[N*18-1 -: 18], vco_half_ps_i + 7 * 30);
    vco_half_ps_i = 16'h00fe;
    clks(8);
    chk(delay_ps_o[N*18-1 -: 18], vco_half_ps_i + 7 * 30);
    chk(delay_ps_o[17:0], 763 + 7 * 30);
    wr(ODSR_OFS_OUT_BASE, 8'hff);
    rd(ODSR_OFS_OUT_BASE, ODSR_OUT_MASK);
    // Oscillator power and format
    for (int k = 0; k < 4; k++) begin
      wr(ODSR_OFS_OSC, k[7:0]);
      chk({osc_out_en_o, osc_out_fmt_o}, {~k[0], k[1]});
    end
    wr(ODSR_OFS_OSC, 8'hfc);
    rd(ODSR_OFS_OSC, 8'h00);
    // Live status is read only
    cond_i = 8'h5a;
    clks(4);
    wr(ODSR_OFS_LIVE, 8'hff);
    rd(ODSR_OFS_LIVE, 8'h5a);
    rd(ODSR_OFS_REFSEL, 8'h98);
    rd(ODSR_OFS_OSCINIT, 8'h04);
    rd(15'h0050, 8'h00);
    // Status output roles on both pins
    cond_i = 8'hea;
    for (int k = 8; k < 13; k++) begin
      wr(ODSR_OFS_PIN_FUNC, {2{k[3:0]}});
      e = k == 8 ? cond_i[3] : k == 9 ? cond_i[2] : k == 10 ? &cond_i[3:2] :
          k == 11 ? ~&cond_i[7:4] : cond_i[1];
      chk({gpio_oe_o, gpio_o}, {2'b11, e, e});
    end
    wr(ODSR_OFS_PIN_POL, 8'h01);
    chk(gpio_o, {2{~cond_i[1]}});
    wr(ODSR_OFS_PIN_POL, 8'h00);
    wr(ODSR_OFS_PIN_FUNC, 8'h0f);
    chk({gpio_oe_o, gpio_o}, {2'b11, refsel_i[2:1]});
    // Latched loss, masking, interrupt and clear
    cond_i = 8'hfd;
    clks(4);
    wr(ODSR_OFS_LATCHED, 8'hff);
    rd(ODSR_OFS_LATCHED, 8'hff);
    wr(ODSR_OFS_PIN_FUNC, 8'hdd);
    cond_i = 8'h7d;
    clks(4);
    cond_i = 8'hfd;
    wr(ODSR_OFS_LATCHED, 8'h00);
    rd(ODSR_OFS_LATCHED, 8'h7f);
    wr(ODSR_OFS_INT_EN, 8'h7f);
    chk(gpio_o, 2'b00);
    wr(ODSR_OFS_INT_EN, 8'h80);
    chk(gpio_o, 2'b11);
    wr(ODSR_OFS_PIN_POL, 8'h01);
    chk(gpio_o, 2'b00);
    wr(ODSR_OFS_PIN_POL, 8'h00);
    wr(ODSR_OFS_LATCHED, 8'h80);
    chk(gpio_o, 2'b00);
    rd(ODSR_OFS_LATCHED, 8'hff);
    // Input roles
    wr(ODSR_OFS_PIN_FUNC, 8'h21);
    for (int k = 0; k < 4; k++) begin
      gpio_i = k[1:0];
      clks(6);
      chk({gpio_oe_o, force_cv_o, force_hold_o}, {2'b00, k[1:0]});
    end
    wr(ODSR_OFS_PIN_FUNC, 8'h87);
    chk({gpio_oe_o, pin_sel_en_o, pin_sel_o}, {2'b00, 1'b1, gpio_i});
    end_sim();
  end
endmodule : test_odsr_top
